// ### rtl/arct_timer.v
`timescale 1ns/1ps
`include "arct_defs.vh"
module arct_timer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        comparator_out,
    input  wire        ext_osc,
    output reg         timer_irq
);
    reg  [7:0]  count_low_byte;
    reg  [7:0]  count_high_byte;
    reg  [7:0]  reload_low_byte;
    reg  [7:0]  reload_high_byte;
    reg         high_overflow_flag;
    reg         low_overflow_flag;
    reg         low_byte_irq_enable;
    reg         capture_enable_bit;
    reg         split_mode_bit;
    reg         run_control_bit;
    reg  [1:0]  ext_clock_select;
    reg         low_byte_clock_select;
    reg         high_byte_clock_select;
    reg         timer_irq_enable;

    reg  [7:0]  next_count_low;
    reg  [7:0]  next_count_high;
    reg  [7:0]  next_reload_low;
    reg  [7:0]  next_reload_high;
    reg         set_high_flag;
    reg         set_low_flag;
    reg  [31:0] next_prdata;
    reg         next_pslverr;

    wire        comp_pulse;
    wire        ext_edge_pulse;
    wire        ext_div8_pulse;
    wire        sys_div12_pulse;
    wire        ext_clock_select_bit1;
    wire        tick_low;
    wire        tick_high;
    wire        capture_event;
    wire        wr_en;
    wire [15:0] count_word;
    wire        irq_cause;

    // write lands at the edge where the access phase completes
    assign wr_en = psel & penable & pready & pwrite;
    assign ext_clock_select_bit1 = ext_clock_select[`ARCT_B_XSEL1];
    assign count_word = {count_high_byte, count_low_byte};

    // about four pclk from a pin edge to a count: latency traded for metastability safety
    arct_sync u_comp_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   (comparator_out),
        .rise_pulse (comp_pulse)
    );

    arct_sync u_ext_sync (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   (ext_osc),
        .rise_pulse (ext_edge_pulse)
    );

    arct_prescale #(.DIV(`ARCT_EXT_DIV)) u_ext_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ext_edge_pulse),
        .pulse   (ext_div8_pulse)
    );

    arct_prescale #(.DIV(`ARCT_SYS_DIV)) u_sys_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (1'b1),
        .pulse   (sys_div12_pulse)
    );

    // per-byte source: select bit high means every system clock
    function src_tick;
        input       sys_sel;
        input [1:0] xsel;
        input       p12;
        input       p8;
        input       pc;
        begin
            if (sys_sel) begin
                src_tick = 1'b1;
            end else begin
                case (xsel)
                    2'b01:   src_tick = p8;
                    2'b11:   src_tick = pc;
                    default: src_tick = p12;
                endcase
            end
        end
    endfunction

    // 16-bit and capture modes are paced by the low-byte select
    assign tick_low  = src_tick(low_byte_clock_select, ext_clock_select,
                                sys_div12_pulse, ext_div8_pulse, comp_pulse);
    assign tick_high = src_tick(high_byte_clock_select, ext_clock_select,
                                sys_div12_pulse, ext_div8_pulse, comp_pulse);

    // bit 1 low picks comparator rising edges, high every eighth external edge
    assign capture_event = capture_enable_bit &
                           (ext_clock_select_bit1 ? ext_div8_pulse
                                                  : comp_pulse);

    always @* begin
        next_count_low   = count_low_byte;
        next_count_high  = count_high_byte;
        next_reload_low  = reload_low_byte;
        next_reload_high = reload_high_byte;
        set_high_flag    = 1'b0;
        set_low_flag     = 1'b0;
        if (split_mode_bit) begin
            if (tick_low) begin
                if (count_low_byte == `ARCT_BYTE_MAX) begin
                    next_count_low = reload_low_byte;
                    set_low_flag   = 1'b1;
                end else begin
                    next_count_low = count_low_byte + 8'h01;
                end
            end
            if (tick_high && run_control_bit) begin
                if (count_high_byte == `ARCT_BYTE_MAX) begin
                    next_count_high = reload_high_byte;
                    set_high_flag   = 1'b1;
                end else begin
                    next_count_high = count_high_byte + 8'h01;
                end
            end
        end else if (tick_low && run_control_bit) begin
            if (count_low_byte == `ARCT_BYTE_MAX) begin
                set_low_flag = 1'b1;
            end
            // capture mode wraps freely so successive captures stay comparable
            if (count_word == `ARCT_WORD_MAX && !capture_enable_bit) begin
                next_count_low  = reload_low_byte;
                next_count_high = reload_high_byte;
                set_high_flag   = 1'b1;
            end else begin
                {next_count_high, next_count_low} = count_word + 16'h0001;
            end
        end
        // capture records the count as it stood before this edge
        if (capture_event) begin
            next_reload_low  = count_low_byte;
            next_reload_high = count_high_byte;
            set_high_flag    = 1'b1;
        end
        // software writes to the count bytes override the hardware step
        if (wr_en) begin
            case (paddr)
                `ARCT_ADDR_CNT_LO: next_count_low = pwdata[7:0];
                `ARCT_ADDR_CNT_HI: next_count_high = pwdata[7:0];
                `ARCT_ADDR_RLD_LO: begin
                    if (!capture_event) begin
                        next_reload_low = pwdata[7:0];
                    end
                end
                `ARCT_ADDR_RLD_HI: begin
                    if (!capture_event) begin
                        next_reload_high = pwdata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_low_byte   <= `ARCT_RST_BYTE;
            count_high_byte  <= `ARCT_RST_BYTE;
        end else begin
            count_low_byte   <= next_count_low;
            count_high_byte  <= next_count_high;
        end
    end

    // reload pair doubles as the capture register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_low_byte  <= `ARCT_RST_BYTE;
            reload_high_byte <= `ARCT_RST_BYTE;
        end else begin
            reload_low_byte  <= next_reload_low;
            reload_high_byte <= next_reload_high;
        end
    end

    // flags: a hardware set in the same cycle as a software clear wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_overflow_flag <= 1'b0;
        end else if (wr_en && paddr == `ARCT_ADDR_CTRL) begin
            high_overflow_flag <= pwdata[`ARCT_B_HFLAG] | set_high_flag;
        end else begin
            high_overflow_flag <= high_overflow_flag | set_high_flag;
        end
    end

    // software may write a flag to one, which raises the request like a wrap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_overflow_flag <= 1'b0;
        end else if (wr_en && paddr == `ARCT_ADDR_CTRL) begin
            low_overflow_flag <= pwdata[`ARCT_B_LFLAG] | set_low_flag;
        end else begin
            low_overflow_flag <= low_overflow_flag | set_low_flag;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_byte_irq_enable    <= 1'b0;
            capture_enable_bit     <= 1'b0;
            split_mode_bit         <= 1'b0;
            run_control_bit        <= 1'b0;
            ext_clock_select       <= 2'b00;
            low_byte_clock_select  <= 1'b0;
            high_byte_clock_select <= 1'b0;
            timer_irq_enable       <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `ARCT_ADDR_CTRL: begin
                    low_byte_irq_enable <= pwdata[`ARCT_B_LIEN];
                    capture_enable_bit  <= pwdata[`ARCT_B_CEN];
                    split_mode_bit      <= pwdata[`ARCT_B_SPLIT];
                    run_control_bit     <= pwdata[`ARCT_B_RUN];
                    ext_clock_select    <= pwdata[1:0];
                end
                `ARCT_ADDR_CLKSEL: begin
                    low_byte_clock_select  <= pwdata[`ARCT_B_CLK_LOW];
                    high_byte_clock_select <= pwdata[`ARCT_B_CLK_HIGH];
                end
                `ARCT_ADDR_IRQEN: timer_irq_enable <= pwdata[`ARCT_B_TIE];
                default: begin
                end
            endcase
        end
    end

    // level request; software finds the source from the two flags
    assign irq_cause = high_overflow_flag |
                       (low_byte_irq_enable & low_overflow_flag);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= timer_irq_enable & irq_cause;
        end
    end

    // unmapped offsets answer with an error and zero data
    always @* begin
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `ARCT_ADDR_CTRL: next_prdata[7:0] = {high_overflow_flag, low_overflow_flag,
                                                 low_byte_irq_enable, capture_enable_bit,
                                                 split_mode_bit, run_control_bit,
                                                 ext_clock_select};
            `ARCT_ADDR_RLD_LO: next_prdata[7:0] = reload_low_byte;
            `ARCT_ADDR_RLD_HI: next_prdata[7:0] = reload_high_byte;
            `ARCT_ADDR_CNT_LO: next_prdata[7:0] = count_low_byte;
            `ARCT_ADDR_CNT_HI: next_prdata[7:0] = count_high_byte;
            `ARCT_ADDR_CLKSEL: next_prdata[1:0] = {high_byte_clock_select,
                                                   low_byte_clock_select};
            `ARCT_ADDR_IRQEN:  next_prdata[0] = timer_irq_enable;
            default:           next_pslverr = 1'b1;
        endcase
    end

    // one wait-free access: answer is prepared during the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel && !penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= next_pslverr;
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end
endmodule

// ### rtl/arct_defs.vh
// Behaviour
// - 16-bit mode: on wrap FFFF to 0000 load reload pair, set high flag.
// - count source: system clock, system clock/12, external/8 or comparator.
// - external/8 and comparator sources are synchronised to the system clock.
// - 16-bit mode: interrupt on every 16-bit overflow when timer irq enabled.
// - 16-bit mode: low-byte irq enable adds an interrupt on each low-byte wrap.
// - split mode: two 8-bit auto-reload timers, each with its own reload byte.
// - split mode: run bit gates the high byte only; low byte always counts.
// - per-byte select 1 gives system clock, else external-clock selection applies.
// - split mode: each byte wrap FF to 00 sets its own overflow flag.
// - split mode: interrupt on high wrap; with low enable on either wrap.
// - overflow flags are never cleared by hardware, only by software writes.
// - capture-enable bit selects capture mode; software keeps split at zero.
// - capture event on comparator rising edge or every 8 external cycles.
// - external-select bit 1 at zero: capture on comparator rising edges.
// - capture copies count into reload pair, sets high flag, may interrupt.
// - control register at index 0x91, reset zero, fixed bit layout.
`ifndef ARCT_DEFS_VH
`define ARCT_DEFS_VH

`define ARCT_IDX_CTRL     8'h91
`define ARCT_IDX_RLD_LO   8'h92
`define ARCT_IDX_RLD_HI   8'h93
`define ARCT_IDX_CNT_LO   8'h94
`define ARCT_IDX_CNT_HI   8'h95
`define ARCT_IDX_CLKSEL   8'h96
`define ARCT_IDX_IRQEN    8'h97

`define ARCT_ADDR_CTRL    {2'b00, `ARCT_IDX_CTRL, 2'b00}
`define ARCT_ADDR_RLD_LO  {2'b00, `ARCT_IDX_RLD_LO, 2'b00}
`define ARCT_ADDR_RLD_HI  {2'b00, `ARCT_IDX_RLD_HI, 2'b00}
`define ARCT_ADDR_CNT_LO  {2'b00, `ARCT_IDX_CNT_LO, 2'b00}
`define ARCT_ADDR_CNT_HI  {2'b00, `ARCT_IDX_CNT_HI, 2'b00}
`define ARCT_ADDR_CLKSEL  {2'b00, `ARCT_IDX_CLKSEL, 2'b00}
`define ARCT_ADDR_IRQEN   {2'b00, `ARCT_IDX_IRQEN, 2'b00}

`define ARCT_B_HFLAG      7
`define ARCT_B_LFLAG      6
`define ARCT_B_LIEN       5
`define ARCT_B_CEN        4
`define ARCT_B_SPLIT      3
`define ARCT_B_RUN        2
`define ARCT_B_XSEL1      1
`define ARCT_B_CLK_LOW    0
`define ARCT_B_CLK_HIGH   1
`define ARCT_B_TIE        0

`define ARCT_RST_BYTE     8'h00
`define ARCT_RST_CTRL     8'h00
`define ARCT_SYS_DIV      4'hC
`define ARCT_EXT_DIV      4'h8
`define ARCT_BYTE_MAX     8'hFF
`define ARCT_WORD_MAX     16'hFFFF

`endif

// ### rtl/arct_sync.v
`timescale 1ns/1ps
module arct_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire async_in,
    output reg  rise_pulse
);
    reg stage1;
    reg stage2;
    reg stage2_d;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1     <= 1'b0;
            stage2     <= 1'b0;
            stage2_d   <= 1'b0;
            rise_pulse <= 1'b0;
        end else begin
            stage1     <= async_in;
            stage2     <= stage1;
            stage2_d   <= stage2;
            rise_pulse <= stage2 & ~stage2_d;
        end
    end
endmodule

// ### rtl/arct_prescale.v
`timescale 1ns/1ps
module arct_prescale #(
    parameter [3:0] DIV = 4'h8
) (
    input  wire pclk,
    input  wire presetn,
    input  wire tick,
    output reg  pulse
);
    reg [3:0] cnt;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt   <= 4'h0;
            pulse <= 1'b0;
        end else if (tick) begin
            if (cnt == DIV - 4'h1) begin
                cnt   <= 4'h0;
                pulse <= 1'b1;
            end else begin
                cnt   <= cnt + 4'h1;
                pulse <= 1'b0;
            end
        end else begin
            pulse <= 1'b0;
        end
    end
endmodule

// ### dv/arct_timer_checker.sv
`timescale 1ns/1ps
`include "arct_defs.vh"
module arct_timer_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        comparator_out,
    input wire logic        ext_osc,
    input wire logic        timer_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire map = paddr[11:2] >= 10'h091 && paddr[11:2] <= 10'h097 && paddr[1:0] == 2'h0;
    wire wr_done = psel && penable && pwrite && pready;

    property p_answer;
        psel && !penable && !pready |=> pready && (pslverr == !$past(map));
    endproperty
    a_answer: assert property (p_answer)
        else $error("setup not answered next cycle");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one)
        else $error("ready longer than one cycle");
    property p_quiet;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("read data outside access");
    property p_width;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_width: assert property (p_width)
        else $error("upper read bits set");
    property p_errz;
        pslverr |-> prdata == 32'h0;
    endproperty
    a_errz: assert property (p_errz)
        else $error("unmapped read data not zero");
    property p_cause;
        pready |-> $past(psel && !penable);
    endproperty
    a_cause: assert property (p_cause)
        else $error("ready without setup");
    property p_access;
        psel && penable |-> pready;
    endproperty
    a_access: assert property (p_access)
        else $error("wait state inserted");
    property p_hold;
        $fell(timer_irq) |-> $past(wr_done) || $past(wr_done, 2);
    endproperty
    a_hold: assert property (p_hold)
        else $error("interrupt dropped without write");
    c_irq: cover property ($rose(timer_irq));
    c_err: cover property (pslverr);
    c_wr: cover property (wr_done);
endmodule

bind arct_timer arct_timer_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comparator_out(comparator_out),
    .ext_osc(ext_osc), .timer_irq(timer_irq));

// ### dv/tb.sv
`timescale 1ns/1ps
`include "arct_defs.vh"
module tb;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic        comparator_out = 0;
    logic        ext_osc = 0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         timer_irq;
    logic [31:0] q;
    logic        e;
    int          n_fail, num_checks, cyc, cnt, rld, fh, fl, ie, cfg, v1;
    logic [11:0] a[7] = '{`ARCT_ADDR_CTRL, `ARCT_ADDR_RLD_LO, `ARCT_ADDR_RLD_HI,
        `ARCT_ADDR_CNT_LO, `ARCT_ADDR_CNT_HI, `ARCT_ADDR_CLKSEL, `ARCT_ADDR_IRQEN};

    arct_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_out(comparator_out), .ext_osc(ext_osc),
        .timer_irq(timer_irq));

    always #4 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic apb(bit w, logic [11:0] ad, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic chk_reg(logic [31:0] got, logic [31:0] x);
        num_checks++;
        if (got !== x) begin
            n_fail++;
            $display("Error %0t: read %h expected %h", $time, got, x);
        end
    endtask
    task automatic chk_irq();
        logic x;
        x = ie && (fh || (cfg[5] && fl));
        repeat (2) @(posedge pclk);
        num_checks++;
        if (timer_irq !== x) begin
            n_fail++;
            $display("Error %0t: interrupt %b expected %b", $time, timer_irq, x);
        end
    endtask
    task automatic rd_chk(logic [11:0] ad, logic [31:0] x, logic [31:0] m = 32'hFFFFFFFF);
        apb(0, ad, 0);
        chk_reg(q & m, x);
    endtask
    task automatic chk_cnt();
        rd_chk(a[3], cnt & 255);
        rd_chk(a[4], (cnt >> 8) & 255);
    endtask
    task automatic ld_cnt();
        apb(1, a[3], cnt & 255);
        apb(1, a[4], (cnt >> 8) & 255);
    endtask
    task automatic setc(int c);
        apb(1, a[0], c);
        cfg = c & 63;
        fh = c[7];
        fl = c[6];
    endtask
    task automatic step(bit tl = 1);
        int lo, hi;
        lo = cnt & 255;
        hi = cnt >> 8;
        if ((cfg[3] || cfg[2]) && tl && lo == 255) fl = 1;
        if (!cfg[3] && cfg[2]) begin
            if (cnt == 65535) begin
                cnt = rld;
                fh = 1;
            end else cnt++;
        end else if (cfg[3]) begin
            if (tl) lo = (lo == 255) ? (rld & 255) : lo + 1;
            if (cfg[2]) begin
                if (hi == 255) fh = 1;
                hi = (hi == 255) ? (rld >> 8) : hi + 1;
            end
            cnt = hi * 256 + lo;
        end
    endtask
    // wide gaps so the synchroniser sees every level
    task automatic pulse();
        comparator_out <= 1;
        repeat (6) @(posedge pclk);
        comparator_out <= 0;
        repeat (8) @(posedge pclk);
    endtask
    task automatic edges(int n);
        repeat (n) begin
            pulse();
            step();
        end
    endtask
    task automatic ext(int n);
        repeat (n) begin
            ext_osc <= 1;
            repeat (3) @(posedge pclk);
            ext_osc <= 0;
            repeat (3) @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        print_verdict();
    end

    initial begin
        v1 = $urandom(32'h124B883D);
        repeat (16) @(posedge pclk);
        presetn <= 1;
        foreach (a[i]) rd_chk(a[i], 0);
        apb(0, 12'h300, 0);
        chk_reg({q[30:0], e}, 32'h1);
        rld = $urandom & 32'hFFFF;
        apb(1, a[1], rld & 255);
        apb(1, a[2], rld >> 8);
        rd_chk(a[1], rld & 255);
        rd_chk(a[2], rld >> 8);
        ie = 1;
        apb(1, a[6], 1);
        cnt = 32'hFFFE;
        ld_cnt();
        setc(8'h07);
        edges(1);
        chk_cnt();
        chk_irq();
        edges(1);
        chk_cnt();
        rd_chk(a[0], fh << 7 | fl << 6 | cfg);
        chk_irq();
        repeat (30) @(posedge pclk);
        rd_chk(a[0], fh << 7 | fl << 6 | cfg);
        setc(8'h03);
        chk_irq();
        edges(3);
        chk_cnt();
        cnt = 32'h12FE;
        ld_cnt();
        setc(8'h27);
        edges(2);
        rd_chk(a[0], fh << 7 | fl << 6 | cfg);
        chk_irq();
        cnt = ($urandom & 32'hFF00) | 32'hFE;
        ld_cnt();
        setc(8'h0B);
        edges(3);
        chk_cnt();
        rd_chk(a[0], fh << 7 | fl << 6 | cfg);
        chk_irq();
        cnt = 32'hFF10;
        ld_cnt();
        setc(8'h0F);
        edges(1);
        chk_cnt();
        chk_irq();
        // high byte on the system clock: a write lands three edges after the call
        setc(8'h0B);
        apb(1, a[5], 2);
        setc(8'h0F);
        repeat (17) @(posedge pclk);
        repeat (20) step(0);
        setc(8'h0B);
        chk_cnt();
        apb(1, a[5], 0);
        setc(8'h05);
        cnt = 32'h0100;
        ld_cnt();
        ext(16);
        step();
        step();
        chk_cnt();
        // system clock / 12 over 120 running edges gives exactly 10 steps
        setc(8'h04);
        repeat (117) @(posedge pclk);
        repeat (10) step();
        setc(8'h00);
        chk_cnt();
        apb(1, a[5], 1);
        setc(8'h14);
        @(posedge pclk);
        v1 = cyc;
        pulse();
        rd_chk(a[0], 32'h80, 32'h80);
        fh = 1;
        chk_irq();
        apb(0, a[1], 0);
        rld = q[7:0];
        apb(0, a[2], 0);
        rld = (rld | q[7:0] << 8) + 100;
        while (cyc != v1 + 100) @(posedge pclk);
        pulse();
        rd_chk(a[1], rld & 255);
        rd_chk(a[2], (rld >> 8) & 255);
        setc(8'h16);
        ext(8);
        rd_chk(a[0], 32'h80, 32'h80);
        print_verdict();
    end
endmodule
